// ===== verilog/timer8_counter_compare_unit.sv
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// Operation
// [R1] Bottom is count value zero
// [R2] Maximum is count value all ones
// [R3] Top is maximum or compare A, per mode
// [R4] Tick from io clock, crystal when selected
// [R5] Each tick clears, increments or decrements
// [R6] Tick source zero stops; counter stays accessible
// [R7] Counter write beats clear and count
// [R8] Three mode bits pick sequence and overflow
// [R9] Equality sets match flag next tick
// [R10] Flags interrupt; clear by service or one
// [R11] Output from match, mode, action, extremes
// [R12] PWM modes double-buffer compare, load at limit
// [R13] Writes hit buffer in PWM, else active
// [R14] Force updates output, no flag, no reload
// [R15] Counter write blocks matches next tick
// [R16] Software avoids writing compare or bottom values
// [R17] Compare output kept across mode changes
// [R18] Actions unbuffered; apply from next match
// [R19] Nonzero action overrides port; direction stays
// [R20] Action zero leaves compare output unchanged
// [R21] Normal mode counts up, overflow at wrap
// [R22] Clear-on-match mode clears at compare A
module timer8_counter_compare_unit
  import timer8_pkg::*;
#(
  parameter int PRESCALE_BITS = PRESCALE_W
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // Crystal clock pin, asynchronous to i_mclk
  input wire logic i_crystal_pin_in,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Interrupt service acknowledges: [0] overflow, [1] match A, [2] match B
  input wire logic [2:0] i_irq_ack,
  // Interrupt requests, same order
  output logic [2:0] o_irq,
  // Compare output pins (output enable low while driven)
  output logic o_compare_output_a,
  output logic o_compare_output_a_oe_n,
  output logic o_compare_output_b,
  output logic o_compare_output_b_oe_n
);

  typedef enum logic [2:0] {
    DIR_UP = 3'b001,
    DIR_DOWN = 3'b010,
    DIR_IDLE = 3'b100
  } dir_state_t;

  reg_req_t req;
  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // Software-visible registers
  logic [7:0] counter_control_a_reg;
  logic [2:0] counter_control_b_reg; // mode bit 2 and tick source bits 1:0; force bits are strobes
  logic [2:0] tick_field_reg;
  logic async_tick_select_reg;
  logic [2:0] flags_reg;
  logic [2:0] flags_next;
  logic [2:0] mask_reg;
  logic [3:0] port_ctrl_reg;
  logic [7:0] count_value_reg;
  logic [7:0] count_value_next;
  logic [7:0] compare_value_a_reg;
  logic [7:0] compare_value_b_reg;
  logic [7:0] buffer_a_reg;
  logic [7:0] buffer_b_reg;
  logic [1:0] compare_output_reg;
  logic block_reg;
  logic [7:0] rdata_reg;
  dir_state_t dir_reg;
  dir_state_t dir_next;
  logic [PRESCALE_BITS-1:0] prescale_reg;

  // Crystal pin synchroniser and edge detector
  logic xtal_meta_reg;
  logic xtal_sync_reg;
  logic xtal_prev_reg;

  // Field decode
  wire [2:0] waveform_mode_field = {counter_control_b_reg[2],
    counter_control_a_reg[FLD_WGM_LO+1:FLD_WGM_LO]};
  wire [1:0] action_a = counter_control_a_reg[FLD_ACT_A+1:FLD_ACT_A];
  wire [1:0] action_b = counter_control_a_reg[FLD_ACT_B+1:FLD_ACT_B];
  wire [2:0] tick_source_select = tick_field_reg;

  // Register write decode
  wire wr_ctrl_a = req.wr && req.addr == OFS_CONTROL_A;
  wire wr_ctrl_b = req.wr && req.addr == OFS_CONTROL_B;
  wire wr_count = req.wr && req.addr == OFS_COUNT;
  wire wr_cmp_a = req.wr && req.addr == OFS_COMPARE_A;
  wire wr_cmp_b = req.wr && req.addr == OFS_COMPARE_B;
  wire wr_async = req.wr && req.addr == OFS_ASYNC_STATE;
  wire wr_flags = req.wr && req.addr == OFS_FLAGS;
  wire wr_mask = req.wr && req.addr == OFS_INT_MASK;
  wire wr_port = req.wr && req.addr == OFS_PORT_CTRL;

  // Mode classes
  wire is_pwm = waveform_mode_field[0]; // [R12]
  wire is_fast = waveform_mode_field[1] && waveform_mode_field[0];
  wire is_phase = waveform_mode_field[0] && !waveform_mode_field[1];
  wire is_ctc = waveform_mode_field == WGM_CTC;
  wire top_is_a = waveform_mode_field[2] || is_ctc; // [R3]
  wire [7:0] top_value = top_is_a ? compare_value_a_reg : CNT_MAX; // [R3]
  wire at_bottom = count_value_reg == CNT_BOTTOM; // [R1]
  wire at_max = count_value_reg == CNT_MAX; // [R2]
  wire at_top = count_value_reg == top_value;

  // Prescaler taps; the full tick source field lives in bits 2:0
  wire [2:0] tick_sel = tick_source_select; // [R6]
  wire [PRESCALE_BITS-1:0] pre_next = prescale_reg + 1'b1;
  wire [PRESCALE_BITS-1:0] rise = pre_next & ~prescale_reg;
  wire xtal_rise = xtal_sync_reg && !xtal_prev_reg;
  wire base_tick = async_tick_select_reg ? xtal_rise : 1'b1; // [R4]
  logic tap;
  always_comb begin
    case (tick_sel)
      TICK_DIV1: tap = 1'b1;
      TICK_DIV8: tap = rise[2];
      TICK_DIV32: tap = rise[4];
      TICK_DIV64: tap = rise[5];
      TICK_DIV128: tap = rise[6];
      TICK_DIV256: tap = rise[7];
      3'h7: tap = rise[PRESCALE_BITS-1];
      default: tap = 1'b0; // [R6]
    endcase
  end
  // Prescaler advances on crystal edges in asynchronous mode
  wire timer_tick = base_tick && tap && !async_tick_select_reg ||
    async_tick_select_reg && xtal_rise && (tick_sel == TICK_DIV1 ||
    (tick_sel != TICK_STOP && tap)); // [R4] [R6]

  // Compare match, blocked for one tick after a counter write
  wire match_a = count_value_reg == compare_value_a_reg && !block_reg; // [R9] [R15]
  wire match_b = count_value_reg == compare_value_b_reg && !block_reg; // [R9] [R15]
  wire force_a = wr_ctrl_b && req.wdata[FLD_FORCE_A] && !is_pwm; // [R14]
  wire force_b = wr_ctrl_b && req.wdata[FLD_FORCE_B] && !is_pwm; // [R14]
  wire [1:0] match_v = {match_b, match_a};
  wire [1:0] force_v = {force_b, force_a};
  wire [3:0] actions = {action_b, action_a};

  // Counter direction and next value
  always_comb begin
    dir_next = dir_reg;
    count_value_next = count_value_reg;
    if (timer_tick) begin
      if (is_phase) begin
        if (dir_reg != DIR_DOWN && at_top) begin
          dir_next = DIR_DOWN;
          count_value_next = count_value_reg - 8'h01; // [R5]
        end else if (dir_reg == DIR_DOWN && at_bottom) begin
          dir_next = DIR_UP;
          count_value_next = count_value_reg + 8'h01; // [R5]
        end else if (dir_reg == DIR_DOWN) begin
          count_value_next = count_value_reg - 8'h01; // [R5]
        end else begin
          count_value_next = count_value_reg + 8'h01;
        end
      end else begin
        dir_next = DIR_UP;
        if ((is_ctc || is_fast) && at_top) begin
          count_value_next = CNT_BOTTOM; // [R22] [R5]
        end else begin
          count_value_next = count_value_reg + 8'h01; // [R21] [R5]
        end
      end
    end
    if (wr_count) begin
      count_value_next = req.wdata; // [R7] [R6]
    end
  end

  // Overflow: normal/clear-on-match at wrap, fast at top, phase at bottom
  wire ovf_event = timer_tick && !wr_count && (is_phase ? (dir_reg == DIR_DOWN && at_bottom) :
    is_fast ? at_top : at_max); // [R8] [R21]
  // Double-buffer load point: fast at top, phase at top while counting up
  wire load_buf = timer_tick && (is_fast ? at_top : (is_phase && at_top && dir_reg != DIR_DOWN));

  // Flags: set wins over clear by write-one or service
  wire [2:0] flag_set = {match_b && timer_tick, match_a && timer_tick, ovf_event}; // [R9]
  wire [2:0] flag_clr = (wr_flags ? req.wdata[2:0] : 3'h0) | i_irq_ack; // [R10]
  assign flags_next = flag_set | (flags_reg & ~flag_clr); // [R10]

  // Waveform generator per channel
  logic [1:0] oc_next;
  logic [1:0] pin_level;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      wire [1:0] act = actions[2*ch+1:2*ch];
      wire hit = match_v[ch] && timer_tick;
      always_comb begin
        oc_next[ch] = compare_output_reg[ch]; // [R17] [R20]
        if (!is_pwm && (hit || force_v[ch])) begin // [R11] [R14]
          case (act) // [R18]
            ACT_TOGGLE: oc_next[ch] = !compare_output_reg[ch];
            ACT_CLEAR: oc_next[ch] = 1'b0;
            ACT_SET: oc_next[ch] = 1'b1;
            default: oc_next[ch] = compare_output_reg[ch]; // [R20]
          endcase
        end else if (is_pwm && act[1]) begin
          if (is_fast && timer_tick && at_top && !(ch == 0 && compare_value_a_reg ==
              CNT_MAX && !top_is_a)) begin
            oc_next[ch] = !act[0]; // [R11] set at bottom, non-inverting
          end else if (hit) begin
            oc_next[ch] = is_phase ? (dir_reg == DIR_DOWN) ^ act[0] : act[0]; // [R11]
          end
        end else if (is_pwm && act == ACT_TOGGLE && ch == 0 && waveform_mode_field[2] && hit) begin
          oc_next[ch] = !compare_output_reg[ch];
        end
      end
      // Port override keeps pin direction under the port bit
      assign pin_level[ch] = act != ACT_NONE ? compare_output_reg[ch] : port_ctrl_reg[ch]; // [R19]
    end
  endgenerate

  // Read mux; compare reads return the buffer in PWM modes, the active value otherwise
  logic [7:0] rd_mux;
  always_comb begin
    case (req.addr)
      OFS_CONTROL_A: rd_mux = counter_control_a_reg;
      OFS_CONTROL_B: rd_mux = {4'h0, counter_control_b_reg[2], tick_field_reg};
      OFS_COUNT: rd_mux = count_value_reg;
      OFS_COMPARE_A: rd_mux = is_pwm ? buffer_a_reg : compare_value_a_reg; // [R13]
      OFS_COMPARE_B: rd_mux = is_pwm ? buffer_b_reg : compare_value_b_reg; // [R13]
      OFS_ASYNC_STATE: rd_mux = {2'h0, async_tick_select_reg, 5'h00};
      OFS_FLAGS: rd_mux = {5'h00, flags_reg};
      OFS_INT_MASK: rd_mux = {5'h00, mask_reg};
      OFS_PORT_CTRL: rd_mux = {4'h0, port_ctrl_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  // Crystal synchroniser; edges come from the second and third stages
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      xtal_meta_reg <= 1'b0;
      xtal_sync_reg <= 1'b0;
      xtal_prev_reg <= 1'b0;
    end else begin
      xtal_meta_reg <= i_crystal_pin_in;
      xtal_sync_reg <= xtal_meta_reg;
      xtal_prev_reg <= xtal_sync_reg;
    end
  end

  // Prescaler runs on io clock or crystal edges
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      prescale_reg <= '0;
    end else if (base_tick) begin
      prescale_reg <= pre_next;
    end
  end

  // Control registers
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      counter_control_a_reg <= RESET_BYTE;
      counter_control_b_reg <= 3'h0;
      tick_field_reg <= TICK_STOP;
      async_tick_select_reg <= 1'b0;
      mask_reg <= 3'h0;
      port_ctrl_reg <= 4'h0;
    end else begin
      if (wr_ctrl_a) counter_control_a_reg <= req.wdata;
      if (wr_ctrl_b) begin
        counter_control_b_reg <= {req.wdata[FLD_WGM_HI], req.wdata[1:0]};
        tick_field_reg <= req.wdata[FLD_TICK_SEL+2:FLD_TICK_SEL];
      end
      if (wr_async) async_tick_select_reg <= req.wdata[FLD_ASYNC_SEL]; // [R4]
      if (wr_mask) mask_reg <= req.wdata[2:0];
      if (wr_port) port_ctrl_reg <= req.wdata[3:0];
    end
  end

  // Counter, compare registers and buffers
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      count_value_reg <= RESET_BYTE;
      dir_reg <= DIR_IDLE;
      compare_value_a_reg <= RESET_BYTE;
      compare_value_b_reg <= RESET_BYTE;
      buffer_a_reg <= RESET_BYTE;
      buffer_b_reg <= RESET_BYTE;
      block_reg <= 1'b0;
    end else begin
      count_value_reg <= count_value_next;
      dir_reg <= dir_next;
      // Block lasts until the next tick has passed
      if (wr_count) block_reg <= 1'b1; // [R15]
      else if (timer_tick) block_reg <= 1'b0;
      if (wr_cmp_a) buffer_a_reg <= req.wdata;
      if (wr_cmp_b) buffer_b_reg <= req.wdata;
      if (!is_pwm && wr_cmp_a) compare_value_a_reg <= req.wdata; // [R13]
      else if (is_pwm && load_buf) compare_value_a_reg <= buffer_a_reg; // [R12]
      if (!is_pwm && wr_cmp_b) compare_value_b_reg <= req.wdata; // [R13]
      else if (is_pwm && load_buf) compare_value_b_reg <= buffer_b_reg; // [R12]
    end
  end

  // Flags, compare outputs and read data
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      flags_reg <= 3'h0;
      compare_output_reg <= 2'h0;
      rdata_reg <= 8'h00;
    end else begin
      flags_reg <= flags_next;
      compare_output_reg <= oc_next; // [R17]
      rdata_reg <= req.rd ? rd_mux : 8'h00;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_irq = flags_reg & mask_reg; // [R10] [R8]
  assign o_compare_output_a = pin_level[0]; // [R19]
  assign o_compare_output_b = pin_level[1];
  assign o_compare_output_a_oe_n = !port_ctrl_reg[2]; // [R19]
  assign o_compare_output_b_oe_n = !port_ctrl_reg[3];

  wire unused_ok = &{1'b0, counter_control_b_reg[1:0]};

endmodule : timer8_counter_compare_unit

// ===== verilog/timer8_pkg.sv
package timer8_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] OFS_CONTROL_A = 4'h0;
  localparam logic [3:0] OFS_CONTROL_B = 4'h1;
  localparam logic [3:0] OFS_COUNT = 4'h2;
  localparam logic [3:0] OFS_COMPARE_A = 4'h3;
  localparam logic [3:0] OFS_COMPARE_B = 4'h4;
  localparam logic [3:0] OFS_ASYNC_STATE = 4'h5;
  localparam logic [3:0] OFS_FLAGS = 4'h6;
  localparam logic [3:0] OFS_INT_MASK = 4'h7;
  localparam logic [3:0] OFS_PORT_CTRL = 4'h8;

  // Control A fields: [7:6] action A, [5:4] action B, [1:0] mode bits 1..0
  localparam int FLD_ACT_A = 6;
  localparam int FLD_ACT_B = 4;
  localparam int FLD_WGM_LO = 0;
  // Control B fields: [7] force A, [6] force B, [3] mode bit 2, [2:0] tick source
  localparam int FLD_FORCE_A = 7;
  localparam int FLD_FORCE_B = 6;
  localparam int FLD_WGM_HI = 3;
  localparam int FLD_TICK_SEL = 0;
  // Flag / mask layout: [2] match B, [1] match A, [0] overflow
  localparam int FLD_FLAG_B = 2;
  localparam int FLD_FLAG_A = 1;
  localparam int FLD_FLAG_OVF = 0;
  // Async state: [5] crystal select. Port ctrl: [3:2] direction B/A, [1:0] port level B/A
  localparam int FLD_ASYNC_SEL = 5;

  // Counter limits
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Waveform modes
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PC_MAX = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_PC_OCRA = 3'h5;
  localparam logic [2:0] WGM_FAST_OCRA = 3'h7;

  // Output actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // Tick sources
  localparam logic [2:0] TICK_STOP = 3'h0;
  localparam logic [2:0] TICK_DIV1 = 3'h1;
  localparam logic [2:0] TICK_DIV8 = 3'h2;
  localparam logic [2:0] TICK_DIV32 = 3'h3;
  localparam logic [2:0] TICK_DIV64 = 3'h4;
  localparam logic [2:0] TICK_DIV128 = 3'h5;
  localparam logic [2:0] TICK_DIV256 = 3'h6;
  localparam int PRESCALE_W = 10;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Per-channel waveform output towards the port
  typedef struct packed {
    logic level;
    logic oe_n;
  } pin_drive_t;

endpackage : timer8_pkg

// ===== verification/timer8_counter_compare_unit_checker.sv
`timescale 1ns/1ps
module timer8_counter_compare_unit_checker
  import timer8_pkg::*;
#(
  parameter int PRESCALE_BITS = PRESCALE_W
) (
  // Clock, reset, crystal
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_crystal_pin_in,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // Interrupts
  input wire logic [2:0] i_irq_ack,
  input wire logic [2:0] o_irq,
  // Compare output pins
  input wire logic o_compare_output_a,
  input wire logic o_compare_output_a_oe_n,
  input wire logic o_compare_output_b,
  input wire logic o_compare_output_b_oe_n
);
  logic [7:0] ctla_reg, ctlb_reg, port_reg, mask_reg;
  default clocking clk_c @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // Shadow setup from write traffic; lands with the design's own registers
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      ctla_reg <= 8'h00;
      ctlb_reg <= 8'h00;
      port_reg <= 8'h00;
      mask_reg <= 8'h00;
    end else if (i_wr) begin
      if (i_addr == OFS_CONTROL_A) ctla_reg <= i_wdata;
      if (i_addr == OFS_CONTROL_B) ctlb_reg <= i_wdata;
      if (i_addr == OFS_PORT_CTRL) port_reg <= i_wdata;
      if (i_addr == OFS_INT_MASK) mask_reg <= i_wdata;
    end
  end
  // Stopped counter means no tick can set a flag or move the count
  wire stopped = ctlb_reg[2:0] == TICK_STOP;
  wire normal = {ctlb_reg[FLD_WGM_HI], ctla_reg[1:0]} == WGM_NORMAL;
  sequence s_wr_cmp;
    i_wr && i_addr == OFS_COMPARE_A && normal;
  endsequence
  sequence s_rd_cmp;
    i_rd && i_addr == OFS_COMPARE_A;
  endsequence
  sequence s_wr_cnt;
    i_wr && i_addr == OFS_COUNT && stopped;
  endsequence
  sequence s_rd_cnt;
    i_rd && i_addr == OFS_COUNT && stopped;
  endsequence
  property p_pin_a;
    ctla_reg[7:6] == ACT_NONE |-> o_compare_output_a == port_reg[0];
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin a not port level");
  property p_pin_b;
    ctla_reg[5:4] == ACT_NONE |-> o_compare_output_b == port_reg[1];
  endproperty
  a_pin_b: assert property (p_pin_b) else $error("pin b not port level");
  property p_oe_a;
    o_compare_output_a_oe_n == !port_reg[2];
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("pin a enable wrong");
  property p_oe_b;
    o_compare_output_b_oe_n == !port_reg[3];
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("pin b enable wrong");
  property p_irq_mask;
    (o_irq & ~mask_reg[2:0]) == 3'h0;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised");
  property p_cmp_direct;
    s_wr_cmp ##2 s_rd_cmp |=> o_rdata == $past(i_wdata, 3);
  endproperty
  a_cmp_direct: assert property (p_cmp_direct) else $error("compare readback");
  property p_cnt_hold;
    s_wr_cnt ##2 s_rd_cnt |=> o_rdata == $past(i_wdata, 3);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("stopped count moved");
  property p_force;
    i_wr && i_addr == OFS_CONTROL_B && i_wdata[FLD_FORCE_A] && i_wdata[3:0] == 4'h0
      && normal && ctla_reg[7:6] == ACT_TOGGLE
      |-> ##2 o_compare_output_a != $past(o_compare_output_a, 2);
  endproperty
  a_force: assert property (p_force) else $error("force did not toggle");
  property p_ack;
    i_irq_ack[0] && stopped && !i_wr |=> !o_irq[0];
  endproperty
  a_ack: assert property (p_ack) else $error("ack left flag set");
endmodule : timer8_counter_compare_unit_checker

// ===== verification/timer8_counter_compare_unit_bench.sv
`timescale 1ns/1ps
module timer8_counter_compare_unit_bench;
  import timer8_pkg::*;
  typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] e;} row_t;
  logic i_mclk, i_resetn, i_crystal_pin_in, i_wr, i_rd;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, d, mx;
  logic [2:0] i_irq_ack, o_irq;
  logic o_compare_output_a, o_compare_output_a_oe_n;
  logic o_compare_output_b, o_compare_output_b_oe_n;
  int n_errors = 0;
  int comparisons = 0;
  int k;
  // Write then read back; force bits read as zero, unmapped reads zero
  row_t rows[8] = '{'{OFS_CONTROL_A, 8'hf0, 8'hf0}, '{OFS_PORT_CTRL, 8'h0c, 8'h0c},
    '{OFS_INT_MASK, 8'h07, 8'h07}, '{OFS_CONTROL_B, 8'hc0, 8'h00},
    '{OFS_COMPARE_A, 8'h5a, 8'h5a}, '{OFS_COMPARE_B, 8'ha5, 8'ha5},
    '{OFS_COUNT, 8'h3c, 8'h3c}, '{4'hf, 8'h77, 8'h00}};
  timer8_counter_compare_unit timer8_counter_compare_unit_inst (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_crystal_pin_in(i_crystal_pin_in),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_irq_ack(i_irq_ack), .o_irq(o_irq), .o_compare_output_a(o_compare_output_a),
    .o_compare_output_a_oe_n(o_compare_output_a_oe_n),
    .o_compare_output_b(o_compare_output_b),
    .o_compare_output_b_oe_n(o_compare_output_b_oe_n));
  // 200 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task results;
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // One idle cycle between strobes keeps each strobe a single assignment per step
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd
  task settle;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask : settle
  // Bounded wait for one interrupt line; k counts clock edges
  task wait_irq(input int b, input int lim);
    k = 0;
    do begin
      @(posedge i_mclk);
      #1 k++;
    end while (o_irq[b] !== 1'b1 && k < lim);
  endtask : wait_irq
  initial begin
    i_resetn = 1'b0;
    i_crystal_pin_in = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_irq_ack = 3'h0;
    repeat (8) @(posedge i_mclk);
    i_resetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk(d, rows[i].e);
    end
    // Forced set on both channels, no flag although unmasked
    chk({4'h0, o_compare_output_b_oe_n, o_compare_output_a_oe_n,
      o_compare_output_b, o_compare_output_a}, 8'h03);
    chk({5'h00, o_irq}, 8'h00);
    wr(OFS_CONTROL_A, 8'h00);
    wr(OFS_PORT_CTRL, 8'h0d);
    settle;
    chk({6'h00, o_compare_output_b, o_compare_output_a}, 8'h01);
    wr(OFS_CONTROL_B, 8'h80);
    wr(OFS_PORT_CTRL, 8'h0c);
    wr(OFS_CONTROL_A, 8'h40);
    settle;
    chk({7'h00, o_compare_output_a}, 8'h01);
    wr(OFS_CONTROL_A, 8'h43);
    settle;
    chk({7'h00, o_compare_output_a}, 8'h01);
    wr(OFS_CONTROL_A, 8'h40);
    wr(OFS_CONTROL_B, 8'h80);
    settle;
    chk({7'h00, o_compare_output_a}, 8'h00);
    // Second reset in mid-run, driven on a clock edge
    @(posedge i_mclk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_resetn <= 1'b1;
    wr(OFS_INT_MASK, 8'h07);
    wr(OFS_COUNT, 8'hfa);
    wr(OFS_CONTROL_B, {5'h00, TICK_DIV1});
    // First tick in the cycle after the write; six ticks reach the wrap
    wait_irq(0, 20);
    chk({7'h00, k == 6}, 8'h01);
    // Two more ticks pass before the stop write lands
    wr(OFS_CONTROL_B, 8'h00);
    rd(OFS_COUNT, d);
    chk(d, 8'h02);
    @(posedge i_mclk);
    i_irq_ack <= 3'h1;
    @(posedge i_mclk);
    i_irq_ack <= 3'h0;
    settle;
    chk({7'h00, o_irq[0]}, 8'h00);
    // Zero count matched both compares above; stale flags would end the next wait
    wr(OFS_FLAGS, 8'h07);
    #1 chk({5'h00, o_irq}, 8'h00);
    // Count written equal to compare: the first tick may not match
    wr(OFS_COMPARE_A, 8'h20);
    wr(OFS_COUNT, 8'h20);
    wr(OFS_CONTROL_B, {5'h00, TICK_DIV1});
    wait_irq(1, 300);
    chk({7'h00, k == 257}, 8'h01);
    wr(OFS_CONTROL_B, 8'h00);
    wr(OFS_FLAGS, 8'h02);
    #1 chk({7'h00, o_irq[1]}, 8'h00);
    // Clear on match at 4: period 5, reads every 2 cycles visit every value
    wr(OFS_COUNT, 8'h01);
    wr(OFS_CONTROL_A, {6'h00, WGM_CTC[1:0]});
    wr(OFS_COMPARE_A, 8'h04);
    wr(OFS_CONTROL_B, {5'h00, TICK_DIV1});
    mx = 8'h00;
    repeat (15) begin
      rd(OFS_COUNT, d);
      if (d > mx) mx = d;
    end
    chk(mx, 8'h04);
    // Crystal ticks only: five rising edges give five counts
    wr(OFS_CONTROL_B, 8'h00);
    wr(OFS_CONTROL_A, 8'h00);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_ASYNC_STATE, 8'h20);
    wr(OFS_CONTROL_B, {5'h00, TICK_DIV1});
    repeat (5) begin
      repeat (4) @(posedge i_mclk);
      i_crystal_pin_in <= 1'b1;
      repeat (4) @(posedge i_mclk);
      i_crystal_pin_in <= 1'b0;
    end
    repeat (6) @(posedge i_mclk);
    wr(OFS_CONTROL_B, 8'h00);
    rd(OFS_COUNT, d);
    chk(d, 8'h05);
    // Fast mode at top 0xff: compare B writes park in the buffer until top
    wr(OFS_ASYNC_STATE, 8'h00);
    wr(OFS_CONTROL_A, 8'h03);
    wr(OFS_COMPARE_B, 8'h10);
    rd(OFS_COMPARE_B, d);
    chk(d, 8'h10);
    wr(OFS_CONTROL_A, 8'h00);
    rd(OFS_COMPARE_B, d);
    chk(d, 8'h00);
    wr(OFS_CONTROL_A, 8'h03);
    wr(OFS_FLAGS, 8'h07);
    wr(OFS_COUNT, 8'hf0);
    wr(OFS_CONTROL_B, {5'h00, TICK_DIV1});
    // Fifteen ticks reach top, the sixteenth flags overflow and loads
    wait_irq(0, 40);
    chk({7'h00, k == 16}, 8'h01);
    wr(OFS_CONTROL_B, 8'h00);
    wr(OFS_CONTROL_A, 8'h00);
    rd(OFS_COMPARE_B, d);
    chk(d, 8'h10);
    results();
  end
  // Watchdog well beyond the several hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_errors++;
    results();
  end
endmodule : timer8_counter_compare_unit_bench

bind timer8_counter_compare_unit timer8_counter_compare_unit_checker #(
  .PRESCALE_BITS(PRESCALE_BITS)) timer8_counter_compare_unit_checker_inst (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_crystal_pin_in(i_crystal_pin_in),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_irq_ack(i_irq_ack), .o_irq(o_irq), .o_compare_output_a(o_compare_output_a),
  .o_compare_output_a_oe_n(o_compare_output_a_oe_n),
  .o_compare_output_b(o_compare_output_b),
  .o_compare_output_b_oe_n(o_compare_output_b_oe_n));
